// file: motor_pwm_slew_current_limit.sv
// Four-channel motor block with slew, current limit, status and interrupt
//
// Behaviour
// - Four independent motor channels each keep command, applied value, slew and limit state.
// - A command is sign-magnitude: bit 7 direction, bits 6:0 PWM magnitude.
// - An applied value of 0x00 brakes the motor with both leads driven low together.
// - An applied value of 0x80 idles the motor with both leads released.
// - On each 100 Hz tick without over-current the applied value moves toward the command by at most the accel step.
// - Every accel step resets to 20.
// - While current is above its limit the applied magnitude is cut step by step.
// - The current limit is set in units of 250 mA.
// - A per-motor over-current flag is set while that limit is exceeded.
// - The applied magnitude of each motor is readable.
// - Reset returns all motor state to defaults with every motor stopped.
`timescale 1ns/100ps
`include "motor_cfg.svh"
module motor_pwm_slew_current_limit
    import motor_pkg::*;
// Periods default to the true rates; a bench may shorten them to keep runs short
#(
    parameter int unsigned UPDATE_PERIOD = `UPDATE_CYCLES,
    parameter int unsigned CUT_PERIOD    = `CUT_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic [7:0]  current0,
    input  wire logic [7:0]  current1,
    input  wire logic [7:0]  current2,
    input  wire logic [7:0]  current3,
    output logic [3:0]       lead_a,
    output logic [3:0]       lead_b,
    output logic [3:0]       lead_oe_n,
    output logic [3:0]       over_current,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Rate enables
    // ------------------------------------------------------------------------
    logic update_tick;
    logic cut_tick;

    tick_divider #(.PERIOD(UPDATE_PERIOD)) u_update
    (
        .clk  (clk),
        .rst  (rst),
        .tick (update_tick)
    );

    // Faster cut rate so a stall is caught well before the next slew step
    tick_divider #(.PERIOD(CUT_PERIOD)) u_cut
    (
        .clk  (clk),
        .rst  (rst),
        .tick (cut_tick)
    );

    // ------------------------------------------------------------------------
    // Current sense synchronisers
    // ------------------------------------------------------------------------
    logic [7:0] cur_meta_q [4];
    logic [7:0] cur_sync_q [4];
    logic [7:0] cur_in     [4];

    assign cur_in[0] = current0;
    assign cur_in[1] = current1;
    assign cur_in[2] = current2;
    assign cur_in[3] = current3;

    // Multi-bit sense is sampled from a slow converter; a torn word lasts one cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cur_meta_q[i] <= 8'h00;
                cur_sync_q[i] <= 8'h00;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                cur_meta_q[i] <= cur_in[i];
                cur_sync_q[i] <= cur_meta_q[i];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    cmd_t       cmd_q   [4];
    cmd_t       cmd_d   [4];
    mag_t       accel_q [4];
    mag_t       accel_d [4];
    logic [7:0] limit_q [4];
    logic [7:0] limit_d [4];
    logic [3:0] irq_en_q;
    logic [3:0] irq_en_d;
    logic [3:0] irq_st_q;
    logic [3:0] irq_st_d;
    logic [3:0] oc_q;
    logic [3:0] oc_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    cmd_t       applied [4];

    function automatic logic [1:0] chan_of(input logic [7:0] a);
        chan_of = a[3:2];
    endfunction : chan_of

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            cmd_d[i]   = cmd_q[i];
            accel_d[i] = accel_q[i];
            limit_d[i] = limit_q[i];
            // Limit register counts 250 mA units; sense uses the same scale
            oc_d[i]    = (cur_sync_q[i] > limit_q[i]);
        end
        irq_en_d = irq_en_q;
        irq_st_d = irq_st_q;
        if (wr)
        begin
            case (addr & 8'hf0)
                8'h00:
                    cmd_d[chan_of(addr)] = wdata[7:0];
                8'h10:
                    accel_d[chan_of(addr)] = wdata[6:0];
                8'h20:
                    limit_d[chan_of(addr)] = wdata[7:0];
                default:
                begin
                    if (addr == `ADDR_IRQ_ENABLE)
                        irq_en_d = wdata[3:0];
                    else if (addr == `ADDR_IRQ_CLEAR)
                        irq_st_d = irq_st_q & ~wdata[3:0];
                end
            endcase
        end
        // Rising over-current sets the sticky bit; set wins over a clear
        irq_st_d = irq_st_d | (oc_d & ~oc_q);

        rdata_d = 32'h0;
        if (rd)
        begin
            case (addr & 8'hf0)
                8'h00:
                    rdata_d = {24'h0, cmd_q[chan_of(addr)]};
                8'h10:
                    rdata_d = {25'h0, accel_q[chan_of(addr)]};
                8'h20:
                    rdata_d = {24'h0, limit_q[chan_of(addr)]};
                8'h30:
                    rdata_d = {24'h0, applied[chan_of(addr)]};
                default:
                begin
                    if (addr == `ADDR_OC_LIVE)
                        rdata_d = {28'h0, oc_q};
                    else if (addr == `ADDR_IRQ_STATUS)
                        rdata_d = {28'h0, irq_st_q};
                    else if (addr == `ADDR_IRQ_ENABLE)
                        rdata_d = {28'h0, irq_en_q};
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cmd_q[i]   <= `CMD_BRAKE;
                accel_q[i] <= `ACCEL_RESET;
                limit_q[i] <= `LIMIT_RESET;
            end
            irq_en_q <= 4'h0;
            irq_st_q <= 4'h0;
            oc_q     <= 4'h0;
            rdata_q  <= 32'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                cmd_q[i]   <= cmd_d[i];
                accel_q[i] <= accel_d[i];
                limit_q[i] <= limit_d[i];
            end
            irq_en_q <= irq_en_d;
            irq_st_q <= irq_st_d;
            oc_q     <= oc_d;
            rdata_q  <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : gen_chan
        motor_channel u_chan
        (
            .clk          (clk),
            .rst          (rst),
            .update_tick  (update_tick),
            .cut_tick     (cut_tick),
            .cmd          (cmd_q[g]),
            .accel        (accel_q[g]),
            .over_current (oc_q[g]),
            .applied      (applied[g]),
            .lead_a       (lead_a[g]),
            .lead_b       (lead_b[g]),
            .lead_oe_n    (lead_oe_n[g])
        );
    end

    assign rdata        = rdata_q;
    assign over_current = oc_q;
    assign irq          = |(irq_st_q & irq_en_q);

endmodule : motor_pwm_slew_current_limit

// file: motor_cfg.svh
// Offsets, field positions, reset values and timing counts of the motor block
`ifndef MOTOR_CFG_SVH
`define MOTOR_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_CMD0        8'h00
`define ADDR_CMD1        8'h04
`define ADDR_CMD2        8'h08
`define ADDR_CMD3        8'h0c
`define ADDR_ACCEL0      8'h10
`define ADDR_ACCEL1      8'h14
`define ADDR_ACCEL2      8'h18
`define ADDR_ACCEL3      8'h1c
`define ADDR_LIMIT0      8'h20
`define ADDR_LIMIT1      8'h24
`define ADDR_LIMIT2      8'h28
`define ADDR_LIMIT3      8'h2c
`define ADDR_APPLIED0    8'h30
`define ADDR_APPLIED1    8'h34
`define ADDR_APPLIED2    8'h38
`define ADDR_APPLIED3    8'h3c
`define ADDR_OC_LIVE     8'h40
`define ADDR_IRQ_STATUS  8'h44
`define ADDR_IRQ_ENABLE  8'h48
`define ADDR_IRQ_CLEAR   8'h4c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CMD_DIR_BIT      7
`define CMD_BRAKE        8'h00
`define CMD_IDLE         8'h80
`define ACCEL_RESET      7'h14
`define LIMIT_RESET      8'h04
`define LIMIT_STEP_MA    250
`define CUR_STEP_CUT     7'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ           40000000
`define UPDATE_HZ        100
`define UPDATE_CYCLES    (`CLK_HZ / `UPDATE_HZ)
`define CUT_HZ           1000
`define CUT_CYCLES       (`CLK_HZ / `CUT_HZ)

`endif

// file: motor_pkg.sv
// Types shared by the motor block
package motor_pkg;

    typedef logic [7:0] cmd_t;
    typedef logic [6:0] mag_t;

    typedef enum logic [1:0]
    {
        drive_brake,
        drive_idle,
        drive_fwd,
        drive_rev
    } drive_e;

endpackage : motor_pkg

// file: tick_divider.sv
// Divider that makes a one-cycle enable pulse every PERIOD clocks
`timescale 1ns/100ps
module tick_divider
#(
    parameter int unsigned PERIOD = 400000
)
(
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);

    logic [31:0] count_q;
    logic [31:0] count_d;

    always_comb
    begin
        if (count_q == PERIOD - 1)
            count_d = 32'h0;
        else
            count_d = count_q + 32'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_q <= 32'h0;
        else
            count_q <= count_d;
    end

    assign tick = (count_q == PERIOD - 1);

endmodule : tick_divider

// file: motor_channel.sv
// One motor channel: slew toward command, current cut, lead drive decode
`timescale 1ns/100ps
`include "motor_cfg.svh"
module motor_channel
    import motor_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic update_tick,
    input  wire logic cut_tick,
    input  wire cmd_t cmd,
    input  wire mag_t accel,
    input  wire logic over_current,
    output cmd_t      applied,
    output logic      lead_a,
    output logic      lead_b,
    output logic      lead_oe_n
);

    // ------------------------------------------------------------------------
    // Slew and current cut
    // ------------------------------------------------------------------------
    cmd_t applied_q;
    cmd_t applied_d;
    logic pwm_q;
    logic pwm_d;
    mag_t pwm_cnt_q;
    mag_t pwm_cnt_d;
    drive_e mode;

    function automatic mag_t step_toward(input mag_t cur, input mag_t tgt, input mag_t st);
        logic [7:0] diff;
        begin
            diff = (cur > tgt) ? {1'b0, cur - tgt} : {1'b0, tgt - cur};
            if (diff <= {1'b0, st})
                step_toward = tgt;
            else if (cur > tgt)
                step_toward = cur - st;
            else
                step_toward = cur + st;
        end
    endfunction : step_toward

    always_comb
    begin
        applied_d = applied_q;
        if (over_current && cut_tick)
        begin
            // Cut only magnitude; direction held so the cut never reverses
            if (applied_q[6:0] > `CUR_STEP_CUT)
                applied_d = {applied_q[7], applied_q[6:0] - `CUR_STEP_CUT};
            else
                applied_d = {applied_q[7], 7'h00};
        end
        else if (!over_current && update_tick)
        begin
            if (applied_q[7] == cmd[7] || applied_q[6:0] == 7'h00)
                // Same direction, or at zero: slew magnitude, stop on target
                applied_d = {cmd[7], step_toward(applied_q[6:0], cmd[6:0], accel)};
            else
                // Reversal passes through zero first
                applied_d = {applied_q[7], step_toward(applied_q[6:0], 7'h00, accel)};
        end
        pwm_cnt_d = pwm_cnt_q + 7'h1;
        pwm_d = (pwm_cnt_q < applied_q[6:0]);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            applied_q <= `CMD_BRAKE;
            pwm_cnt_q <= 7'h00;
            pwm_q     <= 1'b0;
        end
        else
        begin
            applied_q <= applied_d;
            pwm_cnt_q <= pwm_cnt_d;
            pwm_q     <= pwm_d;
        end
    end

    // ------------------------------------------------------------------------
    // Lead drive
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (applied_q == `CMD_BRAKE)
            mode = drive_brake;
        else if (applied_q == `CMD_IDLE)
            mode = drive_idle;
        else if (applied_q[`CMD_DIR_BIT])
            mode = drive_rev;
        else
            mode = drive_fwd;
    end

    always_comb
    begin
        case (mode)
            drive_brake:
            begin
                lead_a    = 1'b0;
                lead_b    = 1'b0;
                lead_oe_n = 1'b0;
            end
            drive_idle:
            begin
                lead_a    = 1'b0;
                lead_b    = 1'b0;
                lead_oe_n = 1'b1;
            end
            drive_fwd:
            begin
                lead_a    = pwm_q;
                lead_b    = 1'b0;
                lead_oe_n = 1'b0;
            end
            drive_rev:
            begin
                lead_a    = 1'b0;
                lead_b    = pwm_q;
                lead_oe_n = 1'b0;
            end
            default:
            begin
                lead_a    = 1'b0;
                lead_b    = 1'b0;
                lead_oe_n = 1'b1;
            end
        endcase
    end

    assign applied = applied_q;

endmodule : motor_channel

// file: motor_monitor.sv
// Port checker for the four-channel motor block
`timescale 1ns/100ps
`include "motor_cfg.svh"
module motor_monitor
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  current0,
    input wire logic [7:0]  current1,
    input wire logic [7:0]  current2,
    input wire logic [7:0]  current3,
    input wire logic [3:0]  lead_a,
    input wire logic [3:0]  lead_b,
    input wire logic [3:0]  lead_oe_n,
    input wire logic [3:0]  over_current,
    input wire logic        irq
);
    // ----
    // Shadow of limit and enable, taken from bus writes
    // ----
    logic [7:0] lim_q [4];
    logic [7:0] lim_d [4];
    logic [7:0] cur   [4];
    logic [3:0] en_q;
    logic [3:0] en_d;

    assign cur = '{current0, current1, current2, current3};

    always_comb
    begin
        lim_d = lim_q;
        en_d  = en_q;
        if (wr && addr[7:4] == 4'h2)
            lim_d[addr[3:2]] = wdata[7:0];
        if (wr && addr == `ADDR_IRQ_ENABLE)
            en_d = wdata[3:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lim_q <= '{default: `LIMIT_RESET};
            en_q  <= 4'h0;
        end
        else
        begin
            lim_q <= lim_d;
            en_q  <= en_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rd_window_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its answer cycle");
    upper_zero_a: assert property ($past(rd) |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    accel_bit_a: assert property ($past(rd) && $past(addr[7:4]) == 4'h1 |-> !rdata[7])
        else $error("accel step bit 7 reads back set");
    unmapped_a: assert property ($past(rd) && $past(addr) > 8'h4f |-> rdata == 32'h0)
        else $error("unmapped read not zero");
    lead_excl_a: assert property ((lead_a & lead_b) == 4'h0)
        else $error("both leads high together");
    reset_state_a: assert property (disable iff (1'b0) rst |-> lead_oe_n == 4'h0 && !irq)
        else $error("motor not braked during reset");
    irq_mask_a: assert property (en_q == 4'h0 ##1 en_q == 4'h0 |-> !irq)
        else $error("interrupt high with all sources masked");

    for (genvar g = 0; g < 4; g++)
    begin : g_ch
        oc_set_a: assert property ((cur[g] > lim_q[g]) [*5] |-> over_current[g])
            else $error("over-current flag missing");
        oc_clr_a: assert property ((cur[g] <= lim_q[g]) [*5] |-> !over_current[g])
            else $error("over-current flag without excess current");
        irq_set_a: assert property ($rose(over_current[g]) && en_q[g] |-> ##[1:2] irq)
            else $error("enabled over-current raised no interrupt");
    end
endmodule : motor_monitor

bind motor_pwm_slew_current_limit motor_monitor u_mon
(
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .current0, .current1, .current2,
    .current3, .lead_a, .lead_b, .lead_oe_n, .over_current, .irq
);

// file: motor_load.sv
// Load model of one DC motor on a driver channel
`timescale 1ns/100ps
module motor_load
(
    input  wire logic lead_a,
    input  wire logic lead_b,
    input  wire logic lead_oe_n,
    input  wire logic stall,
    output logic [7:0] current
);
    // Current in 250 mA units; a stalled rotor draws far more than a free one
    always_comb
    begin
        if (lead_oe_n)
            current = 8'h00;
        else if (stall)
            current = 8'h0a;
        else
            current = (lead_a | lead_b) ? 8'h02 : 8'h01;
    end
endmodule : motor_load

// file: tb_motor_pwm_slew_current_limit.sv
// Self-checking bench of the four-channel motor block
`timescale 1ns/100ps
`include "motor_cfg.svh"
module tb_motor_pwm_slew_current_limit;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  cur [4];
    logic [3:0]  lead_a;
    logic [3:0]  lead_b;
    logic [3:0]  lead_oe_n;
    logic [3:0]  over_current;
    logic        irq;
    logic [3:0]  stall;
    logic [31:0] d;
    int          n_mismatch;
    int          total_checks;

    for (genvar g = 0; g < 4; g++)
    begin : g_load
        motor_load u_load
        (
            .lead_a(lead_a[g]), .lead_b(lead_b[g]), .lead_oe_n(lead_oe_n[g]),
            .stall(stall[g]), .current(cur[g])
        );
    end

    // Short tick periods, same 10:1 ratio, keep the run to a few thousand cycles
    motor_pwm_slew_current_limit #(.UPDATE_PERIOD(1000), .CUT_PERIOD(100)) u_dut
    (
        .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .current0(cur[0]),
        .current1(cur[1]), .current2(cur[2]), .current3(cur[3]), .lead_a,
        .lead_b, .lead_oe_n, .over_current, .irq
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----
    // Bus and report helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand one cycle only, so sample just after the answer edge
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // ----
    // Scenarios
    // ----
    task automatic t_defaults();
        for (int i = 0; i < 4; i++)
        begin
            rd_reg(8'(`ADDR_ACCEL0 + 4 * i));
            chk(d, 32'h14);
            rd_reg(8'(`ADDR_APPLIED0 + 4 * i));
            chk(d, 32'h00);
            rd_reg(8'(`ADDR_LIMIT0 + 4 * i));
            chk(d, 32'h04);
        end
        chk(32'({lead_oe_n, lead_a, lead_b, irq}), 32'h0);
        wr_reg(8'h50, 32'hff);
        rd_reg(8'h50);
        chk(d, 32'h0);
        $display("defaults test done");
    endtask : t_defaults

    // Waits until the first update tick moves channel 0
    task automatic t_slew();
        int n;
        int hi_a;
        int hi_b;
        wr_reg(`ADDR_CMD0, 32'h40);
        wr_reg(`ADDR_CMD1, 32'h05);
        wr_reg(`ADDR_ACCEL2, 32'hff);
        wr_reg(`ADDR_CMD2, 32'h7f);
        wr_reg(`ADDR_CMD3, 32'h80);
        rd_reg(`ADDR_ACCEL2);
        chk(d, 32'h7f);
        d = 32'h0;
        for (n = 0; n < 1000 && d === 32'h0; n++)
            rd_reg(`ADDR_APPLIED0);
        chk(32'(n > 100), 32'h1);
        chk(d, 32'h14);
        rd_reg(`ADDR_APPLIED1);
        chk(d, 32'h05);
        rd_reg(`ADDR_APPLIED2);
        chk(d, 32'h7f);
        rd_reg(`ADDR_APPLIED3);
        chk(d, 32'h80);
        chk(32'(lead_oe_n), 32'h8);
        hi_a = 0;
        hi_b = 0;
        repeat (128)
        begin
            @(posedge clk);
            #1;
            hi_a += lead_a[0];
            hi_b += lead_b[0];
        end
        chk(32'(hi_a), 32'h14);
        chk(32'(hi_b), 32'h0);
        $display("slew test done");
    endtask : t_slew

    task automatic t_cut();
        int n;
        wr_reg(`ADDR_IRQ_ENABLE, 32'h1);
        stall[0] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(32'({over_current, irq}), 32'h03);
        rd_reg(`ADDR_OC_LIVE);
        chk(d, 32'h1);
        d = 32'h14;
        for (n = 0; n < 200 && d === 32'h14; n++)
            rd_reg(`ADDR_APPLIED0);
        chk(d, 32'h13);
        // Limit equal to the current is not an excess
        wr_reg(`ADDR_LIMIT0, 32'h0a);
        repeat (5) @(posedge clk);
        #1;
        chk(32'(over_current), 32'h0);
        rd_reg(`ADDR_APPLIED0);
        chk(d, 32'h13);
        rd_reg(`ADDR_IRQ_STATUS);
        chk(d, 32'h1);
        wr_reg(`ADDR_IRQ_ENABLE, 32'h0);
        @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
        wr_reg(`ADDR_IRQ_ENABLE, 32'h1);
        @(posedge clk);
        #1;
        chk(32'(irq), 32'h1);
        wr_reg(`ADDR_IRQ_CLEAR, 32'h1);
        @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
        stall[0] <= 1'b0;
        $display("current limit test done");
    endtask : t_cut

    task automatic t_reverse();
        int n;
        wr_reg(`ADDR_CMD0, 32'h85);
        d = 32'h13;
        for (n = 0; n < 1000 && d === 32'h13; n++)
            rd_reg(`ADDR_APPLIED0);
        chk(d, 32'h00);
        for (n = 0; n < 1000 && d === 32'h00; n++)
            rd_reg(`ADDR_APPLIED0);
        chk(d, 32'h85);
        $display("reversal test done");
    endtask : t_reverse

    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        stall = 4'h0;
        n_mismatch = 0;
        total_checks = 0;
        do_reset();
        t_defaults();
        t_slew();
        t_cut();
        t_reverse();
        wr_reg(`ADDR_ACCEL0, 32'h33);
        do_reset();
        t_defaults();
        test_done();
    end

    // Slew, cut and reversal waits come to about 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule : tb_motor_pwm_slew_current_limit
